// [hdl/pgco_top.sv]
// PWM channel gating, converter lock status and clock-out control with APB access
//
// Function
// - PWM channel three runs only when its enable and common enable are set.
// - PWM channel two runs only when its enable and common enable are set.
// - PWM channel one runs only when its enable and common enable are set.
// - Two read-only lock flags show each rate converter's lock state, default 0.
// - Chosen clock drives the clock-out pin only while its enable bit is 1.
// - Select field picks crystal, processor, engine, half converter or modulator clock.
// - Common enable 0 disables every PWM channel regardless of individual enables.
// - Clock-type 0 routes crystal out; 1 routes the selected internal clock.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "pgco_map.svh"
module pgco_top (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        lock_one_i,
    input  wire logic        lock_two_i,
    input  wire logic [4:0]  clk_src_i,
    output logic      [2:0]  pwm_en_o,
    output logic             pll_en_o,
    output logic             mclk_out_o,
    output logic             mclk_out_oe_o,
    output logic             irq_o
);
    logic [15:0] ctrl_ff;
    logic [1:0]  lock_meta_ff;
    logic [1:0]  lock_ff;
    logic [1:0]  lock_prev_ff;
    logic [3:0]  stat_ff;
    logic [3:0]  mask_ff;
    logic [15:0] rd_ctrl;
    logic [3:0]  lock_evt;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_mask;
    logic        unmapped;
    logic [31:0] nxt_prdata;
    logic [4:0]  clk_src_meta_ff;
    logic [4:0]  clk_src_ff;
    logic [2:0]  nxt_pwm_en;

    // Bus decode; the slave answers in the first access cycle
    assign wr_acc   = psel_i & penable_i & pwrite_i;
    assign rd_acc   = psel_i & penable_i & ~pwrite_i;
    assign hit_ctrl = (paddr_i == `PGCO_CTRL_OFS);
    assign hit_stat = (paddr_i == `PGCO_IRQ_STAT_OFS);
    assign hit_mask = (paddr_i == `PGCO_IRQ_MASK_OFS);
    assign unmapped = ~(hit_ctrl | hit_stat | hit_mask);

    // Lock inputs come from other clock domains
    // Only the second stage feeds logic; lock_prev_ff reads lock_ff alone
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_meta_ff <= 2'h0;
            lock_ff      <= 2'h0;
            lock_prev_ff <= 2'h0;
        end else begin
            lock_meta_ff <= {lock_two_i, lock_one_i};
            lock_ff      <= lock_meta_ff;
            lock_prev_ff <= lock_ff;
        end
    end

    // Clock source levels arrive from other clock domains; two flops guard against
    // metastability, so a source change reaches the selector two edges late
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_src_meta_ff <= 5'h00;
            clk_src_ff      <= 5'h00;
        end else begin
            clk_src_meta_ff <= clk_src_i;
            clk_src_ff      <= clk_src_meta_ff;
        end
    end

    // Lock gained (bits 1:0) and lock lost (bits 3:2) events
    assign lock_evt = {lock_prev_ff & ~lock_ff, lock_ff & ~lock_prev_ff};

    // Control register; lock bits are not stored, read-only bits ignore writes
    // Bits 15 and 12..10 lie outside this block and read as zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_ff <= `PGCO_CTRL_RST;
        end else if (wr_acc && hit_ctrl) begin
            ctrl_ff <= pwdata_i[15:0] & `PGCO_CTRL_WMASK;
        end
    end

    // Control readback with live lock flags
    // Lock flags are read through the synchroniser, never stored
    always_comb begin
        rd_ctrl = ctrl_ff;
        rd_ctrl[`PGCO_LOCK1_BIT] = lock_ff[0];
        rd_ctrl[`PGCO_LOCK2_BIT] = lock_ff[1];
    end

    // Interrupt mask register
    // Same bit layout as the status register
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_ff <= 4'h0;
        end else if (wr_acc && hit_mask) begin
            mask_ff <= pwdata_i[3:0];
        end
    end

    // Sticky status; a read clears only the bits it reported, so an event that
    // lands between the sampled read data and the clear is kept, and a new
    // event in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_ff <= 4'h0;
        end else if (rd_acc && hit_stat) begin
            stat_ff <= (stat_ff & ~prdata_o[3:0]) | lock_evt;
        end else begin
            stat_ff <= stat_ff | lock_evt;
        end
    end

    // Read data mux
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (hit_ctrl) begin
            nxt_prdata = {16'h0000, rd_ctrl};
        end else if (hit_stat) begin
            nxt_prdata = {28'h000_0000, stat_ff};
        end else if (hit_mask) begin
            nxt_prdata = {28'h000_0000, mask_ff};
        end
    end

    // Registered bus answer: ready in the first cycle of the access phase
    // Read data stand only while ready is high and read zero otherwise
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & unmapped;
            prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? nxt_prdata : 32'h0000_0000;
        end
    end

    // Per-channel gate: individual enable AND common enable, ground otherwise
    for (genvar gi = 0; gi < 3; gi++) begin : g_pwm_gate
        assign nxt_pwm_en[gi] = ctrl_ff[`PGCO_PWM1_BIT + gi]
                                & ctrl_ff[`PGCO_PWM_ALL_BIT];
    end

    // Registered PWM gates so the pins never see a decode glitch
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwm_en_o <= 3'h0;
        end else begin
            pwm_en_o <= nxt_pwm_en;
        end
    end

    // PLL runs while bit 0 is set, bypassed otherwise
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pll_en_o <= 1'b0;
        end else begin
            pll_en_o <= ctrl_ff[`PGCO_PLL_EN_BIT];
        end
    end

    // Clock-out pin enable; pin is held low while disabled
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mclk_out_oe_o <= 1'b0;
        end else begin
            mclk_out_oe_o <= ctrl_ff[`PGCO_MCLK_EN_BIT];
        end
    end

    // Interrupt level, high while any unmasked status bit is set
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_ff & mask_ff);
        end
    end

    // The PWM gate loop above and the select slice below assume three adjacent PWM bits and a three-bit select field
    if (`PGCO_PWM3_BIT - `PGCO_PWM1_BIT != 2) begin : g_bad_pwm_bits
        $error("PWM enable bits must be three adjacent bits");
    end
    if (`PGCO_SEL_MSB - `PGCO_SEL_LSB != 2) begin : g_bad_sel_bits
        $error("clock select field must be three bits wide");
    end

    // Clock source selection and gating
    // The pin carries a sampled copy of the source, so sources above half the
    // system rate alias; a glitch-free clock mux would replace this in silicon
    pgco_clk_mux u_clk_mux (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .clk_type_i (ctrl_ff[`PGCO_CLK_TYPE_BIT]),
        .sel_i      (ctrl_ff[`PGCO_SEL_MSB:`PGCO_SEL_LSB]),
        .out_en_i   (ctrl_ff[`PGCO_MCLK_EN_BIT]),
        .src_i      (clk_src_ff),
        .clk_o      (mclk_out_o),
        .src_o      ()
    );
endmodule

// [hdl/pgco_map.svh]
// Register offsets, field positions and reset values of the PWM gate and clock-out control
`ifndef PGCO_MAP_SVH
`define PGCO_MAP_SVH

`define PGCO_CTRL_OFS      12'h000
`define PGCO_IRQ_STAT_OFS  12'h004
`define PGCO_IRQ_MASK_OFS  12'h008

`define PGCO_PLL_EN_BIT    0
`define PGCO_SEL_LSB       1
`define PGCO_SEL_MSB       3
`define PGCO_MCLK_EN_BIT   4
`define PGCO_LOCK1_BIT     5
`define PGCO_LOCK2_BIT     6
`define PGCO_PWM1_BIT      7
`define PGCO_PWM3_BIT      9
`define PGCO_CLK_TYPE_BIT  13
`define PGCO_PWM_ALL_BIT   14

`define PGCO_CTRL_RST      16'h0000
`define PGCO_CTRL_WMASK    16'h639F
`define PGCO_IRQ_W         4

`endif

// [hdl/pgco_pkg.sv]
// Types shared by the PWM gate and clock-out control
package pgco_pkg;
    typedef enum logic [2:0] {
        PGCO_SRC_XTAL_PLL,
        PGCO_SRC_PROC,
        PGCO_SRC_ENGINE,
        PGCO_SRC_CONV_HALF,
        PGCO_SRC_MOD
    } pgco_clk_src_t;
endpackage

// [hdl/pgco_clk_mux.sv]
// Registered selector of the clock source driven toward the clock-out pin
`timescale 1ns/100ps
module pgco_clk_mux (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_type_i,
    input  wire logic [2:0]  sel_i,
    input  wire logic        out_en_i,
    input  wire logic [4:0]  src_i,
    output logic             clk_o,
    output pgco_pkg::pgco_clk_src_t src_o
);
    pgco_pkg::pgco_clk_src_t nxt_src;

    // Decode type bit and select field into a source
    always_comb begin
        if (!clk_type_i) begin
            nxt_src = pgco_pkg::PGCO_SRC_XTAL_PLL;
        end else begin
            case (sel_i)
                3'h0:    nxt_src = pgco_pkg::PGCO_SRC_XTAL_PLL;
                3'h1:    nxt_src = pgco_pkg::PGCO_SRC_PROC;
                3'h2:    nxt_src = pgco_pkg::PGCO_SRC_ENGINE;
                3'h3:    nxt_src = pgco_pkg::PGCO_SRC_CONV_HALF;
                default: nxt_src = pgco_pkg::PGCO_SRC_MOD;
            endcase
        end
    end

    // Registered source and gated clock level
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_o <= pgco_pkg::PGCO_SRC_XTAL_PLL;
            clk_o <= 1'b0;
        end else begin
            src_o <= nxt_src;
            clk_o <= out_en_i & src_i[nxt_src];
        end
    end
endmodule

// [verif/pgco_far_end.sv]
// Model of the clock sources and rate converters outside the block
`timescale 1ns/100ps
module pgco_far_end (
    input  wire logic       clk_i,
    input  wire logic       hold_i,
    input  wire logic [4:0] pat_i,
    input  wire logic [1:0] lock_i,
    output logic      [4:0] clk_src_o,
    output logic            lock_one_o,
    output logic            lock_two_o
);
    logic [4:0] cnt_ff = 5'h00;
    // Free-running sources unless a fixed level pattern is held
    always_ff @(posedge clk_i) begin
        cnt_ff <= cnt_ff + 5'h01;
    end
    assign clk_src_o  = hold_i ? pat_i : cnt_ff;
    // Converter lock levels as commanded
    assign lock_one_o = lock_i[0];
    assign lock_two_o = lock_i[1];
endmodule

// [verif/pgco_top_monitor.sv]
// Port-level assertions of the clock-out control block
`timescale 1ns/100ps
module pgco_monitor (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        lock_one_i,
    input wire logic        lock_two_i,
    input wire logic [4:0]  clk_src_i,
    input wire logic [2:0]  pwm_en_o,
    input wire logic        pll_en_o,
    input wire logic        mclk_out_o,
    input wire logic        mclk_out_oe_o,
    input wire logic        irq_o
);
    logic wr_c, rd_c;
    // Control register write and read access cycles
    assign wr_c = psel_i && penable_i && pwrite_i && paddr_i == 12'h000;
    assign rd_c = psel_i && penable_i && !pwrite_i && paddr_i == 12'h000;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_pwm_three_gate: assert property (wr_c |-> ##2
        pwm_en_o[2] == ($past(pwdata_i[9], 2) & $past(pwdata_i[14], 2))) else $error("ch3 gate");
    a_pwm_two_gate: assert property (wr_c |-> ##2
        pwm_en_o[1] == ($past(pwdata_i[8], 2) & $past(pwdata_i[14], 2))) else $error("ch2 gate");
    a_pwm_one_gate: assert property (wr_c |-> ##2
        pwm_en_o[0] == ($past(pwdata_i[7], 2) & $past(pwdata_i[14], 2))) else $error("ch1 gate");
    a_common_off: assert property (wr_c && !pwdata_i[14] |-> ##2
        pwm_en_o == 3'h0) else $error("common enable off");
    a_mclk_oe_follow: assert property (wr_c |-> ##2
        mclk_out_oe_o == $past(pwdata_i[4], 2)) else $error("clock-out enable");
    a_mclk_quiet: assert property (!mclk_out_oe_o [*2] |-> !mclk_out_o)
        else $error("clock-out while disabled");
    a_pll_follow: assert property (wr_c |-> ##2
        pll_en_o == $past(pwdata_i[0], 2)) else $error("pll enable");
    a_lock_one_read: assert property (lock_one_i [*6] ##0 rd_c |-> prdata_o[5])
        else $error("lock one flag");
    a_lock_two_read: assert property (!lock_two_i [*6] ##0 rd_c |-> !prdata_o[6])
        else $error("lock two flag");
    cover property (wr_c && pwdata_i[14]);
    cover property (rd_c && prdata_o[5]);
    cover property (irq_o);
endmodule
bind pgco_top pgco_monitor u_mon (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .psel_i        (psel_i),
    .penable_i     (penable_i),
    .pwrite_i      (pwrite_i),
    .paddr_i       (paddr_i),
    .pwdata_i      (pwdata_i),
    .prdata_o      (prdata_o),
    .pready_o      (pready_o),
    .pslverr_o     (pslverr_o),
    .lock_one_i    (lock_one_i),
    .lock_two_i    (lock_two_i),
    .clk_src_i     (clk_src_i),
    .pwm_en_o      (pwm_en_o),
    .pll_en_o      (pll_en_o),
    .mclk_out_o    (mclk_out_o),
    .mclk_out_oe_o (mclk_out_oe_o),
    .irq_o         (irq_o)
);

// [verif/pgco_top_tb.sv]
// Self-checking bench of the clock-out control block
`timescale 1ns/100ps
module pgco_top_tb;
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic        pwrite_i = 1'b0, hold = 1'b1, pready_o, pslverr_o, lock_one_i, lock_two_i;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
    logic [4:0]  clk_src_i, pat = 5'h00;
    logic [2:0]  pwm_en_o;
    logic [1:0]  lock = 2'h0;
    logic        pll_en_o, mclk_out_o, mclk_out_oe_o, irq_o, err;
    int          bad_count = 0, checks_done = 0;
    pgco_top uut (
        .clk_sys_i     (clk_sys_i),
        .rst_n_i       (rst_n_i),
        .psel_i        (psel_i),
        .penable_i     (penable_i),
        .pwrite_i      (pwrite_i),
        .paddr_i       (paddr_i),
        .pwdata_i      (pwdata_i),
        .prdata_o      (prdata_o),
        .pready_o      (pready_o),
        .pslverr_o     (pslverr_o),
        .lock_one_i    (lock_one_i),
        .lock_two_i    (lock_two_i),
        .clk_src_i     (clk_src_i),
        .pwm_en_o      (pwm_en_o),
        .pll_en_o      (pll_en_o),
        .mclk_out_o    (mclk_out_o),
        .mclk_out_oe_o (mclk_out_oe_o),
        .irq_o         (irq_o)
    );
    pgco_far_end far (.clk_i(clk_sys_i), .hold_i(hold), .pat_i(pat), .lock_i(lock),
        .clk_src_o(clk_src_i), .lock_one_o(lock_one_i), .lock_two_o(lock_two_i));
    // Clock at 40 MHz
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer, waiting for the answer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic t_pwm();
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 12'h000, {17'h0_0000, i[3], 4'h0, i[2:0], 7'h00});
            repeat (2) @(posedge clk_sys_i);
            chk(pwm_en_o, i[3] ? i[2:0] : 3'h0);
        end
    endtask
    task automatic t_clk();
        int x;
        for (int i = 0; i < 16; i++) begin
            x = i[3] ? (i[2] ? 4 : i[2:0]) : 0;
            pat <= 5'h01 << x;
            apb(1'b1, 12'h000, {18'h0_0000, i[3], 8'h00, 1'b1, i[2:0], i[0]});
            repeat (3) @(posedge clk_sys_i);
            chk({mclk_out_oe_o, mclk_out_o, pll_en_o}, {2'h3, i[0]});
            pat <= ~(5'h01 << x);
            repeat (4) @(posedge clk_sys_i);
            chk(mclk_out_o, 0);
        end
        apb(1'b1, 12'h000, 32'h0000_0060);
        repeat (3) @(posedge clk_sys_i);
        chk({mclk_out_oe_o, mclk_out_o}, 0);
    endtask
    task automatic t_irq();
        apb(1'b1, 12'h008, 32'h0000_000F);
        lock <= 2'h1;
        repeat (8) @(posedge clk_sys_i);
        chk(irq_o, 1);
        apb(1'b0, 12'h000, 0);
        chk(rd, 32'h0000_0020);
        apb(1'b0, 12'h004, 0);
        chk(rd, 32'h0000_0001);
        repeat (2) @(posedge clk_sys_i);
        chk(irq_o, 0);
        apb(1'b0, 12'h004, 0);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 12'h008, 0);
        lock <= 2'h2;
        repeat (8) @(posedge clk_sys_i);
        chk(irq_o, 0);
        apb(1'b0, 12'h004, 0);
        chk(rd, 32'h0000_0006);
        apb(1'b0, 12'h000, 0);
        chk(rd, 32'h0000_0040);
        apb(1'b0, 12'h010, 0);
        chk({err, rd[30:0]}, 32'h8000_0000);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Main sequence after reset
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        chk({pwm_en_o, pll_en_o, mclk_out_oe_o}, 0);
        t_pwm();
        t_clk();
        t_irq();
        conclude();
    end
    // Watchdog against a hang
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
